/* File: rtl/dcod_pkg.sv */
// shared opcode patterns, decode enumerations and cycle counts for the opcode decoder
// assumes a 16-bit program word fetched on the core clock
package dcod_pkg;

    // exact one-word patterns
    localparam logic [15:0] W_POP_ACC = 16'hbe32;
    localparam logic [15:0] W_PUSH_ACC = 16'hbe3c;
    localparam logic [15:0] W_EXIT = 16'hef00;
    localparam logic [15:0] W_PROD_MINUS = 16'hbe05;
    localparam logic [15:0] W_XOR_HI16 = 16'hbe83;

    // upper-byte patterns
    localparam logic [7:0] UB_STACK_PULL = 8'h8a;
    localparam logic [7:0] UB_MEM_TO_STACK = 8'h76;
    localparam logic [7:0] UB_REPEAT_IMM = 8'hbb;
    localparam logic [7:0] UB_REPEAT_MEM = 8'h0b;
    localparam logic [7:0] UB_AUX_MINUS = 8'h7c;
    localparam logic [7:0] UB_CTRL = 8'hbe;
    localparam logic [7:0] UB_LONG_ALU = 8'hbf;
    localparam logic [7:0] UB_SQR_PLUS = 8'h52;
    localparam logic [7:0] UB_SQR_MINUS = 8'h53;
    localparam logic [7:0] UB_STATUS_ZERO = 8'h8e;
    localparam logic [7:0] UB_STATUS_ONE = 8'h8f;
    localparam logic [7:0] UB_LONG_STORE = 8'hae;
    localparam logic [7:0] UB_SUB_BORROW = 8'h64;
    localparam logic [7:0] UB_SUB_HIGH = 8'h65;
    localparam logic [7:0] UB_SUB_UNSIGNED = 8'h66;
    localparam logic [7:0] UB_SUB_T_SHIFT = 8'h67;
    localparam logic [7:0] UB_SUB_SHORT = 8'hba;
    localparam logic [7:0] UB_ZERO_LOAD_ROUND = 8'h68;

    // nibble and partial patterns
    localparam logic [3:0] NIB_CTRL = 4'h4;
    localparam logic [3:0] NIB_SUB_LONG = 4'ha;
    localparam logic [3:0] NIB_XOR_LONG = 4'hd;
    localparam logic [3:0] NIB_STORE_ACC = 4'h9;
    localparam logic [3:0] NIB_SUB_SHIFT = 4'h3;
    localparam logic [5:0] TOP_COND_EXIT = 6'h3b;
    localparam logic [5:0] PM_FORM_ZERO = 6'h00;

    // control-bit low nibbles under the control upper byte
    localparam logic [3:0] CB_CARRY = 4'hf;
    localparam logic [3:0] CB_RAM_TO_PROG = 4'h5;
    localparam logic [3:0] CB_INT_DISABLE = 4'h1;
    localparam logic [3:0] CB_OVF_MODE = 4'h3;
    localparam logic [3:0] CB_TEST_FLAG = 4'hb;
    localparam logic [3:0] CB_EXT_FLAG = 4'hd;
    localparam logic [3:0] CB_SIGN_EXT = 4'h7;

    // field positions
    localparam int ADDR_MODE_BIT = 7;
    localparam int ACC_HALF_BIT = 11;

    // word, cycle and shift counts
    localparam logic [1:0] WORDS_ONE = 2'h1;
    localparam logic [1:0] WORDS_TWO = 2'h2;
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TWO = 3'h2;
    localparam logic [2:0] CYC_FOUR = 3'h4;
    localparam int SHIFT_OF_16 = 16;

    typedef enum logic [4:0] {
        OP_NONE, OP_STACK_POP_ACC, OP_STACK_PULL_TO_MEMORY, OP_MEMORY_TO_STACK,
        OP_STACK_PUSH_ACC, OP_SUBROUTINE_EXIT, OP_CONDITIONAL_SUBROUTINE_EXIT,
        OP_REPEAT_IMM, OP_REPEAT_MEM, OP_STORE_ACC_HIGH_SHIFTED, OP_STORE_ACC_LOW_SHIFTED,
        OP_AUX_REG_MINUS_SHORT, OP_CONTROL_BIT_SET, OP_PRODUCT_FROM_ACC_MINUS,
        OP_PRODUCT_SHIFT_SELECT, OP_SQUARE_PLUS_PRODUCT, OP_SQUARE_MINUS_PRODUCT,
        OP_STATUS_WORD_STORE, OP_LONG_IMMEDIATE_STORE, OP_SUB_LONG_SHIFT, OP_SUB_SHIFT,
        OP_ACC_MINUS_BORROW, OP_SUB_HIGH, OP_ACC_MINUS_UNSIGNED, OP_ACC_MINUS_T_SHIFT,
        OP_SUB_SHORT, OP_XOR_LONG, OP_ZERO_LOW_LOAD_HIGH_ROUND
    } dcod_op_t;

    typedef enum logic [2:0] {
        CTRL_NONE, CTRL_CARRY, CTRL_RAM_TO_PROG, CTRL_INT_DISABLE,
        CTRL_OVF_MODE, CTRL_TEST_FLAG, CTRL_EXT_FLAG, CTRL_SIGN_EXT
    } dcod_ctrl_t;

    typedef enum logic [1:0] {
        ST_FETCH = 2'b01,
        ST_CONST = 2'b10
    } dcod_st_t;

endpackage

/* File: rtl/dcod_class.sv */
// opcode classifier: one 16-bit word in, operation, control bit, words and cycles out
// assumes a purely combinational use from the decoder on the same clock
`timescale 1ns/1ps
`default_nettype none
module dcod_class (
    input wire logic [15:0] word_i,
    output dcod_pkg::dcod_op_t op_o,
    output dcod_pkg::dcod_ctrl_t ctrl_o,
    output logic [1:0] words_o,
    output logic [2:0] cyc_taken_o,
    output logic [2:0] cyc_not_taken_o
);
    import dcod_pkg::*;

    logic [7:0] ub;
    logic [7:0] lb;
    assign ub = word_i[15:8];
    assign lb = word_i[7:0];

    // exact words are tested before the wider patterns that would swallow them
    always_comb begin
        op_o = OP_NONE;
        ctrl_o = CTRL_NONE;
        words_o = WORDS_ONE;
        cyc_taken_o = CYC_ONE;
        cyc_not_taken_o = CYC_ONE;
        if (word_i == W_POP_ACC) begin
            op_o = OP_STACK_POP_ACC;
        end else if (word_i == W_PUSH_ACC) begin
            op_o = OP_STACK_PUSH_ACC;
        end else if (word_i == W_PROD_MINUS) begin
            op_o = OP_PRODUCT_FROM_ACC_MINUS;
        end else if (word_i == W_XOR_HI16) begin
            op_o = OP_XOR_LONG;
            words_o = WORDS_TWO;
            cyc_taken_o = CYC_TWO;
            cyc_not_taken_o = CYC_TWO;
        end else if (ub == UB_CTRL && lb[7:4] == NIB_CTRL) begin
            op_o = OP_CONTROL_BIT_SET;
            case (lb[3:0])
                CB_CARRY: ctrl_o = CTRL_CARRY;
                CB_RAM_TO_PROG: ctrl_o = CTRL_RAM_TO_PROG;
                CB_INT_DISABLE: ctrl_o = CTRL_INT_DISABLE;
                CB_OVF_MODE: ctrl_o = CTRL_OVF_MODE;
                CB_TEST_FLAG: ctrl_o = CTRL_TEST_FLAG;
                CB_EXT_FLAG: ctrl_o = CTRL_EXT_FLAG;
                CB_SIGN_EXT: ctrl_o = CTRL_SIGN_EXT;
                default: op_o = OP_NONE;
            endcase
        end else if (word_i == W_EXIT) begin
            op_o = OP_SUBROUTINE_EXIT;
            cyc_taken_o = CYC_FOUR;
            cyc_not_taken_o = CYC_FOUR;
        end else if (word_i[15:10] == TOP_COND_EXIT) begin
            op_o = OP_CONDITIONAL_SUBROUTINE_EXIT;
            cyc_taken_o = CYC_FOUR;
            cyc_not_taken_o = CYC_TWO;
        end else if (ub == UB_LONG_ALU && lb[7:4] == NIB_SUB_LONG) begin
            op_o = OP_SUB_LONG_SHIFT;
            words_o = WORDS_TWO;
            cyc_taken_o = CYC_TWO;
            cyc_not_taken_o = CYC_TWO;
        end else if (ub == UB_LONG_ALU && lb[7:4] == NIB_XOR_LONG) begin
            op_o = OP_XOR_LONG;
            words_o = WORDS_TWO;
            cyc_taken_o = CYC_TWO;
            cyc_not_taken_o = CYC_TWO;
        end else if (ub == UB_LONG_ALU && lb[7:2] == PM_FORM_ZERO) begin
            op_o = OP_PRODUCT_SHIFT_SELECT;
        end else if (ub == UB_LONG_STORE) begin
            op_o = OP_LONG_IMMEDIATE_STORE;
            words_o = WORDS_TWO;
            cyc_taken_o = CYC_TWO;
            cyc_not_taken_o = CYC_TWO;
        end else if (word_i[15:12] == NIB_STORE_ACC) begin
            op_o = word_i[ACC_HALF_BIT] ? OP_STORE_ACC_HIGH_SHIFTED
                                        : OP_STORE_ACC_LOW_SHIFTED;
        end else if (word_i[15:12] == NIB_SUB_SHIFT) begin
            op_o = OP_SUB_SHIFT;
        end else begin
            case (ub)
                UB_STACK_PULL: op_o = OP_STACK_PULL_TO_MEMORY;
                UB_MEM_TO_STACK: op_o = OP_MEMORY_TO_STACK;
                UB_REPEAT_IMM: op_o = OP_REPEAT_IMM;
                UB_REPEAT_MEM: op_o = OP_REPEAT_MEM;
                UB_AUX_MINUS: op_o = OP_AUX_REG_MINUS_SHORT;
                UB_SQR_PLUS: op_o = OP_SQUARE_PLUS_PRODUCT;
                UB_SQR_MINUS: op_o = OP_SQUARE_MINUS_PRODUCT;
                UB_STATUS_ZERO: op_o = OP_STATUS_WORD_STORE;
                UB_STATUS_ONE: op_o = OP_STATUS_WORD_STORE;
                UB_SUB_BORROW: op_o = OP_ACC_MINUS_BORROW;
                UB_SUB_HIGH: op_o = OP_SUB_HIGH;
                UB_SUB_UNSIGNED: op_o = OP_ACC_MINUS_UNSIGNED;
                UB_SUB_T_SHIFT: op_o = OP_ACC_MINUS_T_SHIFT;
                UB_SUB_SHORT: op_o = OP_SUB_SHORT;
                UB_ZERO_LOAD_ROUND: op_o = OP_ZERO_LOW_LOAD_HIGH_ROUND;
                default: op_o = OP_NONE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: rtl/dcod_fields.sv */
// operand field extraction for a classified opcode word
// assumes the operation comes from the classifier on the same word
`timescale 1ns/1ps
`default_nettype none
module dcod_fields (
    input wire logic [15:0] word_i,
    input wire dcod_pkg::dcod_op_t op_i,
    output logic addr_indirect_o,
    output logic [6:0] addr_field_o,
    output logic [4:0] shift_count_field_o,
    output logic [7:0] imm8_o,
    output logic status_word_one_o,
    output logic [1:0] prod_shift_mode_o,
    output logic [1:0] cond_tp_o,
    output logic [3:0] cond_mask_o,
    output logic [3:0] cond_val_o
);
    import dcod_pkg::*;

    assign addr_indirect_o = word_i[ADDR_MODE_BIT];
    assign addr_field_o = word_i[6:0];
    assign imm8_o = word_i[7:0];
    assign status_word_one_o = (word_i[15:8] == UB_STATUS_ONE);
    assign prod_shift_mode_o = word_i[1:0];
    assign cond_tp_o = word_i[9:8];
    assign cond_mask_o = word_i[7:4];
    assign cond_val_o = word_i[3:0];

    always_comb begin
        case (op_i)
            OP_STORE_ACC_HIGH_SHIFTED, OP_STORE_ACC_LOW_SHIFTED:
                shift_count_field_o = {2'h0, word_i[10:8]};
            OP_SUB_SHIFT: shift_count_field_o = {1'h0, word_i[11:8]};
            OP_SUB_LONG_SHIFT: shift_count_field_o = {1'h0, word_i[3:0]};
            OP_XOR_LONG: begin
                if (word_i == W_XOR_HI16) begin
                    shift_count_field_o = 5'(SHIFT_OF_16);
                end else begin
                    shift_count_field_o = {1'h0, word_i[3:0]};
                end
            end
            default: shift_count_field_o = 5'h00;
        endcase
    end
endmodule
`default_nettype wire

/* File: rtl/dcod_decode.sv */
// top of the opcode decoder: takes program words, classifies them, holds two-word forms
// until their constant word arrives and presents one registered decode per operation.
// assumes instruction words come from logic on the same clock, one per valid cycle.
//
// Operation
// - exact word pops stack into low accumulator
// - upper byte pulls stack top into memory
// - upper byte pushes memory word onto stack
// - exact word pushes low accumulator onto stack
// - exit four cycles; conditional exit four or two
// - repeat count from immediate or memory
// - store accumulator half shifted; bit 11 half
// - subtract short immediate from auxiliary register
// - control forms: block to program, interrupts off
// - control byte sets one named control bit
// - exact word subtracts product from accumulator
// - product shift mode select form
// - square plus or minus previous product
// - store status word zero or one
// - two-word store of constant to memory
// - two-word subtract shifted constant from accumulator
// - subtract shifted memory value from accumulator
// - subtract with borrow; subtract from high half
// - subtract unsigned; subtract shifted by multiplier operand
// - subtract short immediate from accumulator
// - two-word exclusive-or shifted constant, incl shift 16
// - zero low half, load high with rounding
`timescale 1ns/1ps
`default_nettype none
module dcod_decode (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_word_i,
    output logic awaiting_const_o,
    output logic op_valid_o,
    output dcod_pkg::dcod_op_t op_o,
    output dcod_pkg::dcod_ctrl_t ctrl_bit_o,
    output logic [1:0] words_o,
    output logic [2:0] cycles_taken_o,
    output logic [2:0] cycles_not_taken_o,
    output logic addr_indirect_o,
    output logic [6:0] addr_field_o,
    output logic [4:0] shift_count_field_o,
    output logic [7:0] imm8_o,
    output logic status_word_one_o,
    output logic [1:0] prod_shift_mode_o,
    output logic [1:0] cond_tp_o,
    output logic [3:0] cond_mask_o,
    output logic [3:0] cond_val_o,
    output logic const_valid_o,
    output logic [15:0] const_word_o,
    output logic unknown_o
);
    import dcod_pkg::*;

    typedef struct packed {
        dcod_st_t st;
        logic op_valid;
        dcod_op_t op;
        dcod_ctrl_t ctrl;
        logic [1:0] words;
        logic [2:0] cyc_t;
        logic [2:0] cyc_n;
        logic ind;
        logic [6:0] addr;
        logic [4:0] shift;
        logic [7:0] imm;
        logic st1;
        logic [1:0] pm;
        logic [1:0] tp;
        logic [3:0] cm;
        logic [3:0] cv;
        logic kvalid;
        logic [15:0] kword;
        logic unknown;
    } dcod_state_t;

    dcod_state_t cur_ff;
    dcod_state_t nxt_cur;

    dcod_op_t cls_op;
    dcod_ctrl_t cls_ctrl;
    logic [1:0] cls_words;
    logic [2:0] cls_cyc_t;
    logic [2:0] cls_cyc_n;
    logic f_ind;
    logic [6:0] f_addr;
    logic [4:0] f_shift;
    logic [7:0] f_imm;
    logic f_st1;
    logic [1:0] f_pm;
    logic [1:0] f_tp;
    logic [3:0] f_cm;
    logic [3:0] f_cv;

    dcod_class u_class (
        .word_i(instr_word_i),
        .op_o(cls_op),
        .ctrl_o(cls_ctrl),
        .words_o(cls_words),
        .cyc_taken_o(cls_cyc_t),
        .cyc_not_taken_o(cls_cyc_n)
    );

    dcod_fields u_fields (
        .word_i(instr_word_i),
        .op_i(cls_op),
        .addr_indirect_o(f_ind),
        .addr_field_o(f_addr),
        .shift_count_field_o(f_shift),
        .imm8_o(f_imm),
        .status_word_one_o(f_st1),
        .prod_shift_mode_o(f_pm),
        .cond_tp_o(f_tp),
        .cond_mask_o(f_cm),
        .cond_val_o(f_cv)
    );

    // decode fields stay on the outputs until the next accepted opcode word
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.op_valid = 1'b0;
        nxt_cur.kvalid = 1'b0;
        case (cur_ff.st)
            ST_FETCH: begin
                if (instr_valid_i) begin
                    nxt_cur.op = cls_op;
                    nxt_cur.ctrl = cls_ctrl;
                    nxt_cur.words = cls_words;
                    nxt_cur.cyc_t = cls_cyc_t;
                    nxt_cur.cyc_n = cls_cyc_n;
                    nxt_cur.ind = f_ind;
                    nxt_cur.addr = f_addr;
                    nxt_cur.shift = f_shift;
                    nxt_cur.imm = f_imm;
                    nxt_cur.st1 = f_st1;
                    nxt_cur.pm = f_pm;
                    nxt_cur.tp = f_tp;
                    nxt_cur.cm = f_cm;
                    nxt_cur.cv = f_cv;
                    nxt_cur.unknown = (cls_op == OP_NONE);
                    if (cls_words == WORDS_TWO) begin
                        nxt_cur.st = ST_CONST;
                    end else begin
                        nxt_cur.op_valid = 1'b1;
                    end
                end
            end
            ST_CONST: begin
                // the operand word bypasses the classifier so it is never issued as an opcode
                if (instr_valid_i) begin
                    nxt_cur.kword = instr_word_i;
                    nxt_cur.kvalid = 1'b1;
                    nxt_cur.op_valid = 1'b1;
                    nxt_cur.st = ST_FETCH;
                end
            end
            default: begin
                nxt_cur.st = ST_FETCH;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cur_ff <= '0;
            cur_ff.st <= ST_FETCH;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign awaiting_const_o = (cur_ff.st == ST_CONST);
    assign op_valid_o = cur_ff.op_valid;
    assign op_o = cur_ff.op;
    assign ctrl_bit_o = cur_ff.ctrl;
    assign words_o = cur_ff.words;
    assign cycles_taken_o = cur_ff.cyc_t;
    assign cycles_not_taken_o = cur_ff.cyc_n;
    assign addr_indirect_o = cur_ff.ind;
    assign addr_field_o = cur_ff.addr;
    assign shift_count_field_o = cur_ff.shift;
    assign imm8_o = cur_ff.imm;
    assign status_word_one_o = cur_ff.st1;
    assign prod_shift_mode_o = cur_ff.pm;
    assign cond_tp_o = cur_ff.tp;
    assign cond_mask_o = cur_ff.cm;
    assign cond_val_o = cur_ff.cv;
    assign const_valid_o = cur_ff.kvalid;
    assign const_word_o = cur_ff.kword;
    assign unknown_o = cur_ff.unknown;

    logic fetch_take;
    assign fetch_take = instr_valid_i && (cur_ff.st == ST_FETCH);

    pop_acc_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i == W_POP_ACC)
        |=> (op_valid_o && op_o == OP_STACK_POP_ACC && words_o == 2'h1 && cycles_taken_o == 3'h1))
        else $error("pop to accumulator not decoded");

    pull_mem_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i[15:8] == 8'h8a)
        |=> (op_valid_o && op_o == OP_STACK_PULL_TO_MEMORY
             && addr_field_o == $past(instr_word_i[6:0])))
        else $error("stack pull to memory wrong");

    push_mem_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i[15:8] == 8'h76) |=> (op_o == OP_MEMORY_TO_STACK))
        else $error("memory to stack wrong");

    push_acc_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i == 16'hbe3c) |=> (op_valid_o && op_o == OP_STACK_PUSH_ACC))
        else $error("push accumulator wrong");

    exit_cycles_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i[15:10] == 6'h3b)
        |=> (cycles_taken_o == 3'h4
             && cycles_not_taken_o == ($past(instr_word_i) == 16'hef00 ? 3'h4 : 3'h2)))
        else $error("exit cycle counts wrong");

    repeat_sel_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i[15:8] == 8'hbb)
        |=> (op_o == OP_REPEAT_IMM && imm8_o == $past(instr_word_i[7:0])))
        else $error("repeat immediate wrong");

    store_half_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i[15:12] == 4'h9)
        |=> ((op_o == OP_STORE_ACC_HIGH_SHIFTED) == $past(instr_word_i[11])
             && shift_count_field_o == {2'h0, $past(instr_word_i[10:8])}))
        else $error("accumulator store half or shift wrong");

    aux_minus_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i[15:8] == 8'h7c) |=> (op_o == OP_AUX_REG_MINUS_SHORT))
        else $error("aux register subtract wrong");

    ctrl_bits_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i == 16'hbe4d) |=> (ctrl_bit_o == CTRL_EXT_FLAG))
        else $error("external flag set wrong");

    int_disable_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i == 16'hbe41) |=> (ctrl_bit_o == CTRL_INT_DISABLE))
        else $error("interrupt disable wrong");

    status_sel_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i[15:9] == 7'h47)
        |=> (op_o == OP_STATUS_WORD_STORE && status_word_one_o == $past(instr_word_i[8])))
        else $error("status word store wrong");

    // the opcode half is held silently; the idle gap before the constant may be any length
    two_word_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i[15:8] == 8'hae)
        |=> (!op_valid_o && awaiting_const_o && op_o == OP_LONG_IMMEDIATE_STORE))
        else $error("two-word opcode not held for its constant");

    const_take_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (awaiting_const_o && instr_valid_i)
        |=> (op_valid_o && const_valid_o && !awaiting_const_o && op_o == $past(op_o)
             && const_word_o == $past(instr_word_i)))
        else $error("constant word decoded as an opcode");

    prod_minus_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i == 16'hbe05)
        |=> (op_valid_o && op_o == OP_PRODUCT_FROM_ACC_MINUS))
        else $error("product subtract not decoded");

    sub_shift_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i[15:12] == 4'h3)
        |=> (op_valid_o && op_o == OP_SUB_SHIFT
             && shift_count_field_o == {1'h0, $past(instr_word_i[11:8])}))
        else $error("shifted memory subtract wrong");

    sub_long_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i[15:4] == 12'hbfa)
        |=> (awaiting_const_o && op_o == OP_SUB_LONG_SHIFT
             && shift_count_field_o == {1'h0, $past(instr_word_i[3:0])}))
        else $error("long subtract with shift wrong");

    square_sel_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i[15:9] == 7'h29)
        |=> (op_valid_o && op_o == ($past(instr_word_i[8]) ? OP_SQUARE_MINUS_PRODUCT
                                                           : OP_SQUARE_PLUS_PRODUCT)))
        else $error("square form wrong");

    sub_short_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i[15:8] == 8'hba)
        |=> (op_valid_o && op_o == OP_SUB_SHORT && imm8_o == $past(instr_word_i[7:0])))
        else $error("short immediate subtract wrong");

    xor16_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (fetch_take && instr_word_i == 16'hbe83)
        |=> (op_o == OP_XOR_LONG && shift_count_field_o == 5'h10 && words_o == 2'h2))
        else $error("xor with shift of 16 wrong");

    ind_mode_a: assert property (
        @(posedge clock_i) disable iff (rst_i)
        fetch_take |=> (addr_indirect_o == $past(instr_word_i[7])))
        else $error("addressing mode bit wrong");

endmodule
`default_nettype wire

/* File: testbench/dsp_core_opcode_decode_tb.sv */
// self-checking bench for the opcode decoder: a table of words, a queue of expected decodes
// assumes dcod_pkg and the rtl decoder files are compiled first
`timescale 1ns/1ps
`default_nettype none
module dsp_core_opcode_decode_tb;
import dcod_pkg::*;
typedef struct {
    logic [15:0] w; dcod_op_t op; logic m; logic [4:0] sh;
    dcod_ctrl_t c; logic [1:0] n; logic [2:0] ct; logic [2:0] cn;
} dcod_case_t;
logic clock_i = 1'b0;
logic rst_i = 1'b1;
logic instr_valid_i = 1'b0;
logic [15:0] instr_word_i = 16'h0000;
logic awaiting_const_o, op_valid_o, addr_indirect_o, status_word_one_o, const_valid_o, unknown_o;
dcod_op_t op_o;
dcod_ctrl_t ctrl_bit_o;
logic [1:0] words_o, prod_shift_mode_o, cond_tp_o;
logic [2:0] cycles_taken_o, cycles_not_taken_o;
logic [6:0] addr_field_o;
logic [4:0] shift_count_field_o;
logic [7:0] imm8_o;
logic [3:0] cond_mask_o, cond_val_o;
logic [15:0] const_word_o;
int failures = 0;
int compares = 0;
logic [31:0] seed = 32'hb6af;
logic [3:0] nib [7] = '{4'hf, 4'h5, 4'h1, 4'h3, 4'hb, 4'hd, 4'h7};
dcod_case_t cases[$];
dcod_case_t notes[$];
logic [15:0] cnotes[$];
dcod_decode dcod_decode_i (
    .clock_i(clock_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .instr_word_i(instr_word_i), .awaiting_const_o(awaiting_const_o),
    .op_valid_o(op_valid_o), .op_o(op_o), .ctrl_bit_o(ctrl_bit_o), .words_o(words_o),
    .cycles_taken_o(cycles_taken_o), .cycles_not_taken_o(cycles_not_taken_o),
    .addr_indirect_o(addr_indirect_o), .addr_field_o(addr_field_o),
    .shift_count_field_o(shift_count_field_o), .imm8_o(imm8_o),
    .status_word_one_o(status_word_one_o), .prod_shift_mode_o(prod_shift_mode_o),
    .cond_tp_o(cond_tp_o), .cond_mask_o(cond_mask_o), .cond_val_o(cond_val_o),
    .const_valid_o(const_valid_o), .const_word_o(const_word_o), .unknown_o(unknown_o)
);
always #2 clock_i = ~clock_i;
function automatic logic [31:0] nx();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
endfunction
task automatic summarize();
    if (failures == 0 && compares > 0) begin
        $display("Test passed");
    end else begin
        $display("Test failed");
    end
    $finish;
endtask
task automatic chk(input logic ok);
    compares++;
    if (ok !== 1'b1) begin
        failures++;
        $display("[ERR] %0t decode mismatch", $time);
    end
endtask
task automatic ad(input logic [15:0] w, input dcod_op_t op, input logic m = 1'b0,
    input logic [4:0] sh = 5'h00, input dcod_ctrl_t c = CTRL_NONE,
    input logic [1:0] n = WORDS_ONE, input logic [2:0] ct = CYC_ONE,
    input logic [2:0] cn = CYC_ONE);
    cases.push_back('{w, op, m, sh, c, n, ct, cn});
endtask
task automatic put(input logic [15:0] w, input logic v);
    @(negedge clock_i);
    instr_valid_i = v;
    instr_word_i = w;
endtask
// a result with no note behind it means a constant word was decoded as an opcode
always @(negedge clock_i) begin : mon
    dcod_case_t e;
    logic [15:0] k;
    if (op_valid_o === 1'b1) begin
        if (notes.size() == 0) begin
            chk(1'b0);
        end else begin
            e = notes.pop_front();
            k = cnotes.pop_front();
            chk(op_o === e.op && unknown_o === (e.op == OP_NONE));
            if (e.op != OP_NONE) begin
                chk(ctrl_bit_o === e.c && words_o === e.n && cycles_taken_o === e.ct);
                chk(cycles_not_taken_o === e.cn && shift_count_field_o === e.sh);
                chk(status_word_one_o === (e.w[15:8] == 8'h8f));
                chk(imm8_o === e.w[7:0] && {cond_tp_o, cond_mask_o, cond_val_o} === e.w[9:0]);
            end
            if (e.op == OP_PRODUCT_SHIFT_SELECT) chk(prod_shift_mode_o === e.w[1:0]);
            if (e.m) chk(addr_indirect_o === e.w[7] && addr_field_o === e.w[6:0]);
            chk(const_valid_o === (e.n == WORDS_TWO));
            if (e.n == WORDS_TWO) chk(const_word_o === k);
        end
    end
end
initial begin : main
    dcod_case_t e;
    logic [31:0] r;
    logic [15:0] k;
    repeat (20) @(negedge clock_i);
    rst_i = 1'b0;
    chk(op_valid_o === 1'b0 && awaiting_const_o === 1'b0 && op_o === OP_NONE);
    ad(16'hbe32, OP_STACK_POP_ACC);
    ad(16'h8a00, OP_STACK_PULL_TO_MEMORY, 1);
    ad(16'h7600, OP_MEMORY_TO_STACK, 1);
    ad(16'hbe3c, OP_STACK_PUSH_ACC);
    ad(16'hef00, OP_SUBROUTINE_EXIT, 0, 0, CTRL_NONE, WORDS_ONE, CYC_FOUR, CYC_FOUR);
    ad(16'hed31, OP_CONDITIONAL_SUBROUTINE_EXIT, 0, 0, CTRL_NONE, 1, CYC_FOUR, CYC_TWO);
    ad(16'hbb7f, OP_REPEAT_IMM);
    ad(16'h0b00, OP_REPEAT_MEM, 1);
    ad(16'h9d00, OP_STORE_ACC_HIGH_SHIFTED, 1, 5'h05);
    ad(16'h9200, OP_STORE_ACC_LOW_SHIFTED, 1, 5'h02);
    ad(16'h7c33, OP_AUX_REG_MINUS_SHORT);
    for (int j = 0; j < 7; j++) ad({8'hbe, 4'h4, nib[j]}, OP_CONTROL_BIT_SET, 0, 0, dcod_ctrl_t'(j + 1));
    ad(16'hbe05, OP_PRODUCT_FROM_ACC_MINUS);
    ad(16'hbf02, OP_PRODUCT_SHIFT_SELECT);
    ad(16'h5200, OP_SQUARE_PLUS_PRODUCT, 1);
    ad(16'h5300, OP_SQUARE_MINUS_PRODUCT, 1);
    ad(16'h8e00, OP_STATUS_WORD_STORE, 1);
    ad(16'h8f00, OP_STATUS_WORD_STORE, 1);
    ad(16'hae00, OP_LONG_IMMEDIATE_STORE, 1, 0, CTRL_NONE, WORDS_TWO, CYC_TWO, CYC_TWO);
    ad(16'hbfa9, OP_SUB_LONG_SHIFT, 0, 5'h09, CTRL_NONE, WORDS_TWO, CYC_TWO, CYC_TWO);
    ad(16'h3c00, OP_SUB_SHIFT, 1, 5'h0c);
    ad(16'h6400, OP_ACC_MINUS_BORROW, 1);
    ad(16'h6500, OP_SUB_HIGH, 1);
    ad(16'h6600, OP_ACC_MINUS_UNSIGNED, 1);
    ad(16'h6700, OP_ACC_MINUS_T_SHIFT, 1);
    ad(16'hba44, OP_SUB_SHORT);
    ad(16'hbfdf, OP_XOR_LONG, 0, 5'h0f, CTRL_NONE, WORDS_TWO, CYC_TWO, CYC_TWO);
    ad(16'hbe83, OP_XOR_LONG, 0, 5'h10, CTRL_NONE, WORDS_TWO, CYC_TWO, CYC_TWO);
    ad(16'h6800, OP_ZERO_LOW_LOAD_HIGH_ROUND, 1);
    ad(16'h0a00, OP_NONE);
    foreach (cases[i]) begin
        e = cases[i];
        r = nx();
        if (e.m) e.w[7:0] = r[7:0];
        // odd cases carry a constant that itself looks like a valid opcode
        k = i[0] ? 16'hbe32 : r[31:16];
        notes.push_back(e);
        cnotes.push_back(k);
        put(e.w, 1'b1);
        if (e.n == WORDS_TWO) begin
            if (r[8]) put(~k, 1'b0);
            put(k, 1'b1);
            chk(awaiting_const_o === 1'b1);
        end
        if (r[9]) put(r[15:0], 1'b0);
    end
    put(16'h0000, 1'b0);
    repeat (4) @(negedge clock_i);
    chk(notes.size() == 0);
    summarize();
end
initial begin : watchdog
    #40000;
    failures++;
    summarize();
end
endmodule
`default_nettype wire
